// ---- ccm_pkg.sv ----
// Contract
// - answer control code 0101, programmable nibble
// - next three bits are address bits 10..8
// - direction bit: 1 read, 0 write
// - acknowledge every accepted control byte
// - pointer loads block bits plus word address
// - acknowledge word address, then take data
// - acknowledge data byte; master then stops
// - commit data at its acknowledge
// - restart keeps pointer, drops pending write
// - after read control, ack then send byte
// - lock options block reads or writes
// - security lock active by default
package ccm_pkg;

	// ------------------------------------------------------------
	// constants
	// ------------------------------------------------------------
	localparam logic [3:0]  CTRL_CODE_RST  = 4'h5;     // 0x28 >> 3
	localparam int          ADDR_W         = 11;       // bits 10..0
	localparam int          DEPTH          = 2048;     // bytes reachable
	localparam logic [10:0] LOCK_LIMIT     = 11'h0bf;  // byte 191 holds bit 1535
	localparam logic [2:0]  LOCK_RST       = 3'h5;     // read-low+write-all, active default

	// lock options
	typedef enum logic [2:0] {
		ccm_lock_none      = 3'h0,
		ccm_lock_rd_low    = 3'h1,
		ccm_lock_wr_low    = 3'h2,
		ccm_lock_wr_all    = 3'h3,
		ccm_lock_rdwr_low  = 3'h4,
		ccm_lock_rd_wr_all = 3'h5
	} ccm_lock_t;

	// serial pins grouped
	typedef struct packed {
		logic scl;  // clock level
		logic sda;  // data level
	} ccm_bus_t;

endpackage

// ---- ccm_cond_det.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// start / stop detector and scl edge finder
// ------------------------------------------------------------
module ccm_cond_det (
	input  wire logic          core_clk,
	input  wire logic          arst_n,
	input  wire ccm_pkg::ccm_bus_t bus_in,
	output logic               start_p,
	output logic               stop_p,
	output logic               scl_rise,
	output logic               scl_fall
);
	ccm_pkg::ccm_bus_t prev;  // previous sample

	// sample pins each cycle
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			prev <= '{scl: 1'b1, sda: 1'b1};
		end else begin
			prev <= bus_in;
		end
	end

	// conditions from sda edges while scl high
	always_comb begin
		start_p  = prev.scl && bus_in.scl && prev.sda && !bus_in.sda;
		stop_p   = prev.scl && bus_in.scl && !prev.sda && bus_in.sda;
		scl_rise = !prev.scl && bus_in.scl;
		scl_fall = prev.scl && !bus_in.scl;
	end
endmodule // ccm_cond_det
`default_nettype wire

// ---- ccm_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// configuration byte memory, synchronous write, async read
// ------------------------------------------------------------
module ccm_mem #(
	parameter int AW = ccm_pkg::ADDR_W
) (
	input  wire logic          core_clk,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [7:0]    wr_data,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [7:0]    rd_data
);
	logic [7:0] mem [0:(1<<AW)-1];  // storage array

	initial begin
		if (AW < 8) $error("address width too small");
	end

	// byte write
	always_ff @(posedge core_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	assign rd_data = mem[rd_addr];
endmodule // ccm_mem
`default_nettype wire

// ---- ccm_target.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// i2c target giving byte access to configuration memory
// ------------------------------------------------------------
module ccm_target (
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_oe_n,     // low = pull sda low
	input  wire logic [3:0]  ctrl_code,    // programmed control code
	input  wire logic [2:0]  lock_sel,     // lock option
	input  wire logic        lock_default, // take reset lock instead
	output logic [10:0]      addr_ptr,     // internal address pointer
	output logic             wr_commit,    // pulse, byte stored
	output logic             wr_blocked,   // pulse, write refused by lock
	output logic             busy          // inside addressed transaction
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ccm_idle = 3'b000,
		ccm_ctrl = 3'b001,
		ccm_word = 3'b011,
		ccm_data = 3'b010,
		ccm_send = 3'b110,
		ccm_mack = 3'b111
	} ccm_state_t;

	ccm_state_t state;        // byte phase
	logic [7:0] shreg;        // receive shifter
	logic [7:0] txreg;        // transmit shifter
	logic [3:0] bitcnt;       // bits of current byte
	logic       ack_slot;     // acking in ninth bit
	logic [2:0] blk;          // block bits latched
	logic       start_p, stop_p, scl_rise, scl_fall;
	logic [7:0] rd_byte;      // memory at pointer
	logic       mem_we;       // write strobe
	logic [2:0] lock_eff;     // lock option in force
	logic       rd_lock, wr_lock;
	logic [7:0] next_byte;    // byte with newest bit

	ccm_cond_det u_det (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.bus_in   ('{scl: scl_in, sda: sda_in}),
		.start_p  (start_p),
		.stop_p   (stop_p),
		.scl_rise (scl_rise),
		.scl_fall (scl_fall)
	);

	ccm_mem u_mem (
		.core_clk (core_clk),
		.wr_en    (mem_we),
		.wr_addr  (addr_ptr),
		.wr_data  (shreg),
		.rd_addr  (addr_ptr),
		.rd_data  (rd_byte)
	);

	// ------------------------------------------------------------
	// lock decode
	// ------------------------------------------------------------
	always_comb begin
		lock_eff = lock_default ? ccm_pkg::LOCK_RST : lock_sel;
		rd_lock  = 1'b0;
		wr_lock  = 1'b0;
		unique case (ccm_pkg::ccm_lock_t'(lock_eff))
			ccm_pkg::ccm_lock_rd_low:    rd_lock = addr_ptr <= ccm_pkg::LOCK_LIMIT;
			ccm_pkg::ccm_lock_wr_low:    wr_lock = addr_ptr <= ccm_pkg::LOCK_LIMIT;
			ccm_pkg::ccm_lock_wr_all:    wr_lock = 1'b1;
			ccm_pkg::ccm_lock_rdwr_low: begin
				rd_lock = addr_ptr <= ccm_pkg::LOCK_LIMIT;
				wr_lock = addr_ptr <= ccm_pkg::LOCK_LIMIT;
			end
			ccm_pkg::ccm_lock_rd_wr_all: begin
				rd_lock = addr_ptr <= ccm_pkg::LOCK_LIMIT;
				wr_lock = 1'b1;
			end
			default: ;
		endcase
		next_byte = {shreg[6:0], sda_in};
	end

	// data byte stored as its ack begins
	assign mem_we = (state == ccm_data) && scl_fall && (bitcnt == 4'h8) && !ack_slot
		&& !wr_lock;

	// ------------------------------------------------------------
	// protocol engine
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state    <= ccm_idle;
			shreg    <= 8'h00;
			txreg    <= 8'hff;
			bitcnt   <= 4'h0;
			ack_slot <= 1'b0;
			blk      <= 3'h0;
			addr_ptr <= 11'h000;
			sda_oe_n <= 1'b1;
			wr_commit  <= 1'b0;
			wr_blocked <= 1'b0;
			busy     <= 1'b0;
		end else begin
			wr_commit  <= 1'b0;
			wr_blocked <= 1'b0;
			if (stop_p) begin
				state    <= ccm_idle;
				sda_oe_n <= 1'b1;
				ack_slot <= 1'b0;
				busy     <= 1'b0;
			end else if (start_p) begin
				// restart keeps pointer, drops write
				state    <= ccm_ctrl;
				bitcnt   <= 4'h0;
				ack_slot <= 1'b0;
				sda_oe_n <= 1'b1;
			end else if (state != ccm_idle || ack_slot) begin
				// idle with ack pending must still release its ack
				if (scl_rise && !ack_slot && state != ccm_send) begin
					shreg  <= next_byte;
					bitcnt <= bitcnt + 4'h1;
				end
				if (scl_rise && state == ccm_mack && ack_slot) begin
					// master ack continues, nack ends
					if (sda_in) state <= ccm_idle;
					else state <= ccm_send;
				end
				if (scl_fall) begin
					if (ack_slot) begin
						// release after ack bit
						ack_slot <= 1'b0;
						bitcnt   <= 4'h0;
						sda_oe_n <= 1'b1;
						if (state == ccm_send) begin
							// reload from pointer so later bytes are fresh
							sda_oe_n <= rd_byte[7] | rd_lock;
							txreg    <= {rd_byte[6:0], 1'b1};
							bitcnt   <= 4'h1;
						end
					end else if (state == ccm_send) begin
						if (bitcnt == 4'h8) begin
							sda_oe_n <= 1'b1;
							ack_slot <= 1'b1;
							state    <= ccm_mack;
							addr_ptr <= addr_ptr + 11'h001;
						end else begin
							sda_oe_n <= txreg[7] | rd_lock;
							txreg    <= {txreg[6:0], 1'b1};
							bitcnt   <= bitcnt + 4'h1;
						end
					end else if (bitcnt == 4'h8) begin
						unique case (state)
							ccm_ctrl: begin
								if (shreg[7:4] == ctrl_code) begin
									sda_oe_n <= 1'b0;
									ack_slot <= 1'b1;
									busy     <= 1'b1;
									blk      <= shreg[3:1];
									if (shreg[0]) begin
										state <= ccm_send;
										txreg <= rd_byte;
									end else begin
										state <= ccm_word;
									end
								end else begin
									state <= ccm_idle;
								end
							end
							ccm_word: begin
								addr_ptr <= {blk, shreg};
								sda_oe_n <= 1'b0;
								ack_slot <= 1'b1;
								state    <= ccm_data;
							end
							ccm_data: begin
								sda_oe_n   <= 1'b0;
								ack_slot   <= 1'b1;
								wr_commit  <= !wr_lock;
								wr_blocked <= wr_lock;
								state      <= ccm_idle;
							end
							default: state <= ccm_idle;
						endcase
					end
				end
			end
			if (state == ccm_idle && !ack_slot && !start_p) begin
				busy <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence ctrl_done_s;
		state == ccm_ctrl && scl_fall && bitcnt == 4'h8 && !ack_slot && !start_p && !stop_p;
	endsequence

	property match_ack_p;
		@(posedge core_clk) disable iff (!arst_n)
		ctrl_done_s and (shreg[7:4] == ctrl_code) |=> !sda_oe_n;
	endproperty
	ctrl_ack_a: assert property (match_ack_p) else $error("no ack on matching code");

	mismatch_nack_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		ctrl_done_s and (shreg[7:4] != ctrl_code) |=> sda_oe_n && state == ccm_idle)
		else $error("ack on foreign code");

	ptr_load_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		state == ccm_word && scl_fall && bitcnt == 4'h8 && !ack_slot && !start_p && !stop_p
		|=> addr_ptr == {blk, $past(shreg)}) else $error("pointer not loaded");

	commit_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		mem_we |=> wr_commit && !sda_oe_n) else $error("commit not at ack");

	lock_wr_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		wr_lock |-> !mem_we) else $error("locked write stored");

	restart_ptr_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		start_p |=> $stable(addr_ptr) && state == ccm_ctrl) else $error("restart lost pointer");

	rd_dir_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		ctrl_done_s and (shreg[7:4] == ctrl_code) |=>
		(state == (shreg[0] ? ccm_send : ccm_word))) else $error("direction wrong");

	advance_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		state == ccm_send && scl_fall && !ack_slot && bitcnt == 4'h8 && !start_p && !stop_p
		|=> addr_ptr == $past(addr_ptr) + 11'h001) else $error("pointer not advanced");

endmodule // ccm_target
`default_nettype wire

// ---- ccm_i2c_master.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// bus master model, open drain line with pull-up
// ------------------------------------------------------------
module ccm_i2c_master (
	input  wire logic core_clk,
	input  wire logic sda_oe_n,
	output logic      scl_in,
	output logic      sda_in
);
	logic scl_m; // master clock level, idles high
	logic sda_m; // master data, 1 = released

	// wired line: pulled up unless someone pulls low
	assign scl_in = scl_m;
	assign sda_in = sda_m & sda_oe_n;

	initial begin
		scl_m = 1'b1;
		sda_m = 1'b1;
	end

	// wait some falling edges
	task automatic hold(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	// start or repeated start
	task automatic start();
		sda_m = 1'b1;
		hold(4);
		scl_m = 1'b1;
		hold(4);
		sda_m = 1'b0;
		hold(4);
		scl_m = 1'b0;
		hold(2);
	endtask

	// stop ends the frame
	task automatic stop();
		sda_m = 1'b0;
		hold(4);
		scl_m = 1'b1;
		hold(4);
		sda_m = 1'b1;
		hold(4);
	endtask

	// eight bits msb first, then the acknowledge slot
	task automatic xfer(input logic [7:0] d, input logic mack,
			output logic [7:0] q, output logic ack_n);
		for (int i = 8; i >= 0; i--) begin
			sda_m = (i == 0) ? mack : d[i-1];
			hold(4);
			scl_m = 1'b1;
			hold(4);
			if (i == 0)
				ack_n = sda_in;
			else
				q[i-1] = sda_in;
			scl_m = 1'b0;
			hold(2);
		end
		sda_m = 1'b1;
	endtask
endmodule // ccm_i2c_master
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        core_clk, arst_n, scl_in, sda_in, sda_oe_n;
	logic        lock_default, wr_commit, wr_blocked, busy;
	logic [3:0]  ctrl_code;
	logic [2:0]  lock_sel;
	logic [10:0] addr_ptr;
	logic [7:0]  q, sh_lo, sh_hi;
	logic        a;
	int          fail_count, samples_checked, cyc, n_commit, n_block;

	ccm_target ccm_target_i (.core_clk(core_clk), .arst_n(arst_n), .scl_in(scl_in),
		.sda_in(sda_in), .sda_oe_n(sda_oe_n), .ctrl_code(ctrl_code), .lock_sel(lock_sel),
		.lock_default(lock_default), .addr_ptr(addr_ptr), .wr_commit(wr_commit),
		.wr_blocked(wr_blocked), .busy(busy));
	ccm_i2c_master ccm_i2c_master_i (.core_clk(core_clk), .sda_oe_n(sda_oe_n),
		.scl_in(scl_in), .sda_in(sda_in));

	// 100 MHz clock
	always #5 core_clk = ~core_clk;

	// pulse counters and hang limit
	always @(posedge core_clk) begin
		cyc++;
		if (wr_commit === 1'b1) n_commit++;
		if (wr_blocked === 1'b1) n_block++;
		if (cyc == 40000) begin
			fail_count++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		if (fail_count == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// send a byte, compare the acknowledge
	task automatic send(input logic [7:0] d, input logic ack_exp);
		ccm_i2c_master_i.xfer(d, 1'b1, q, a);
		chk("ack_n", {10'h0, ~ack_exp}, {10'h0, a});
	endtask

	// byte write, compare commit and refusal counts
	task automatic wr(input logic [10:0] ad, input logic [7:0] d, input logic blk);
		int c0, b0;
		c0 = n_commit;
		b0 = n_block;
		ccm_i2c_master_i.start();
		send({ctrl_code, ad[10:8], 1'b0}, 1'b1);
		send(ad[7:0], 1'b1);
		send(d, 1'b1);
		chk("commit", 11'(!blk), 11'(n_commit - c0));
		chk("blocked", 11'(blk), 11'(n_block - b0));
		ccm_i2c_master_i.stop();
	endtask

	// random read, then pointer one beyond
	task automatic rd(input logic [10:0] ad, input logic [7:0] e);
		ccm_i2c_master_i.start();
		send({ctrl_code, ad[10:8], 1'b0}, 1'b1);
		chk("busy", 11'h1, {10'h0, busy});
		send(ad[7:0], 1'b1);
		ccm_i2c_master_i.start();
		send({ctrl_code, ad[10:8], 1'b1}, 1'b1);
		ccm_i2c_master_i.xfer(8'hff, 1'b1, q, a);
		chk("rd_data", {3'h0, e}, {3'h0, q});
		ccm_i2c_master_i.stop();
		chk("addr_ptr", ad + 11'h1, addr_ptr);
	endtask

	initial begin
		core_clk = 1'b0;
		arst_n = 1'b0;
		ctrl_code = 4'h5;
		lock_sel = 3'h0;
		lock_default = 1'b0;
		repeat (4) @(negedge core_clk);
		arst_n = 1'b1;
		chk("sda_oe_n", 11'h1, {10'h0, sda_oe_n});
		chk("addr_ptr", 11'h0, addr_ptr);
		chk("busy", 11'h0, {10'h0, busy});
		// write, random read, current-address read
		wr(11'h234, 8'ha5, 1'b0);
		wr(11'h235, 8'h3c, 1'b0);
		rd(11'h234, 8'ha5);
		ccm_i2c_master_i.start();
		send({ctrl_code, 3'h2, 1'b1}, 1'b1);
		ccm_i2c_master_i.xfer(8'hff, 1'b1, q, a);
		chk("rd_data", 11'h03c, {3'h0, q});
		ccm_i2c_master_i.stop();
		chk("addr_ptr", 11'h236, addr_ptr);
		// foreign code ignored, programmed code obeyed
		ccm_i2c_master_i.start();
		send(8'ha0, 1'b0);
		chk("busy", 11'h0, {10'h0, busy});
		ccm_i2c_master_i.stop();
		ctrl_code = 4'h6;
		wr(11'h300, 8'h77, 1'b0);
		rd(11'h300, 8'h77);
		ctrl_code = 4'h5;
		// every lock option at the range boundary
		for (int s = 0; s < 6; s++) begin
			lock_sel = s[2:0];
			wr(11'h0bf, 8'h10 + 8'(s), s >= 2);
			if (s < 2) sh_lo = 8'h10 + 8'(s);
			wr(11'h0c0, 8'h20 + 8'(s), s == 3 || s == 5);
			if (s != 3 && s != 5) sh_hi = 8'h20 + 8'(s);
			rd(11'h0bf, (s == 1 || s >= 4) ? 8'hff : sh_lo);
			rd(11'h0c0, sh_hi);
		end
		// default security lock overrides the option
		lock_sel = 3'h0;
		lock_default = 1'b1;
		rd(11'h0bf, 8'hff);
		wr(11'h0c0, 8'h99, 1'b1);
		report_and_stop();
	end
endmodule // testbench
`default_nettype wire
